// ==== inc/ucd_map.svh ====
// Offsets, field positions, reset values and timing constants of the serial port.
// Assumes inclusion by bare name from the design files.
`ifndef UCD_MAP_SVH
`define UCD_MAP_SVH

// ==========================================================================
// Register addresses
`define UCD_ADDR_CONTROL      8'h98
`define UCD_ADDR_DATA         8'h99

// ==========================================================================
// Control register fields
`define UCD_BIT_MODE          7
`define UCD_BIT_UNUSED        6
`define UCD_BIT_MPE           5
`define UCD_BIT_REN           4
`define UCD_BIT_TB9           3
`define UCD_BIT_RB9           2
`define UCD_BIT_TDONE         1
`define UCD_BIT_RDONE         0

// ==========================================================================
// Reset values
`define UCD_RST_CONTROL       8'h40
`define UCD_RST_DATA          8'h00
`define UCD_RD_UNMAPPED       8'h00

// ==========================================================================
// Timing: reload timer overflows twice per bit
`define UCD_TICKS_PER_BIT     2'h2
`define UCD_DATA_BITS         4'h8
`define UCD_TIMER_TOP         8'hff
`define UCD_RST_RELOAD        8'h96

`endif

// ==== inc/ucd_pkg.sv ====
// Types shared by the serial port design.
// Assumes ucd_map.svh is compiled alongside.
package ucd_pkg;

   // ========================================================================
   // Transmit and receive sequencer states
   typedef enum logic [2:0] {
      UCD_IDLE,
      UCD_START,
      UCD_DATA,
      UCD_NINTH,
      UCD_STOP
   } ucd_state_t;

endpackage : ucd_pkg

// ==== hw/ucd_baud_timer.sv ====
// Eight-bit auto-reload timer giving one tick per overflow.
// Assumes the reload value is held steady by software while a frame runs.
`timescale 1ns/1ns
`include "ucd_map.svh"
module ucd_baud_timer #(
   parameter int WIDTH = 8
) (
   input  wire logic             clk,
   input  wire logic             rst,
   input  wire logic             restart,
   input  wire logic [WIDTH-1:0] reload,
   output logic                  tick
);
   logic [WIDTH-1:0] count;
   wire              wrap = (count == {WIDTH{1'b1}});

   // ========================================================================
   // Count up from reload, tick on overflow
   always_ff @(posedge clk) begin
      if (rst) begin
         count <= '0;
         tick  <= 1'b0;
      end else if (restart) begin
         count <= reload;
         tick  <= 1'b0;
      end else begin
         count <= wrap ? reload : count + 1'b1;
         tick  <= wrap;
      end
   end
endmodule : ucd_baud_timer

// ==== hw/ucd_serial_port.sv ====
// Control, status and data buffer logic of an asynchronous serial port.
// Assumes a one-clock special register port and a remote party on RXD/TXD.
`timescale 1ns/1ns
`include "ucd_map.svh"

module ucd_serial_port
   import ucd_pkg::*;
(
   input  wire logic       CLK_SYS,
   input  wire logic       RST,
   input  wire logic [7:0] SFR_ADDR,
   input  wire logic       SFR_WR,
   input  wire logic       SFR_RD,
   input  wire logic [7:0] SFR_WDATA,
   output logic      [7:0] SFR_RDATA,
   input  wire logic [7:0] BAUD_RELOAD,
   input  wire logic       IRQ_ENABLE,
   input  wire logic       RXD,
   output logic            TXD,
   output logic            IRQ
);
   // =======================================================================
   // Register decode
   wire wr_ctrl = SFR_WR && (SFR_ADDR == `UCD_ADDR_CONTROL);
   wire wr_data = SFR_WR && (SFR_ADDR == `UCD_ADDR_DATA);
   wire rd_ctrl = SFR_RD && (SFR_ADDR == `UCD_ADDR_CONTROL);
   wire rd_data = SFR_RD && (SFR_ADDR == `UCD_ADDR_DATA);

   logic       framing_mode_select;
   logic       multiprocessor_enable;
   logic       receive_enable_bit;
   logic       ninth_transmit_bit;
   logic       ninth_receive_bit;
   logic       transmit_done_flag;
   logic       receive_done_flag;
   logic [7:0] receive_latch;

   wire [7:0] ctrl_value = {framing_mode_select, 1'b1, multiprocessor_enable,
                            receive_enable_bit, ninth_transmit_bit, ninth_receive_bit,
                            transmit_done_flag, receive_done_flag};
   wire [7:0] next_rdata = rd_ctrl ? ctrl_value :
                           rd_data ? receive_latch :
                           `UCD_RD_UNMAPPED;

   // =======================================================================
   // Receive pin synchroniser, change accepted when stages two and three agree
   logic rx_s1;
   logic rx_s2;
   logic rx_s3;
   logic rx_level;

   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         rx_s1    <= 1'b1;
         rx_s2    <= 1'b1;
         rx_s3    <= 1'b1;
         rx_level <= 1'b1;
      end else begin
         rx_s1 <= RXD;
         rx_s2 <= rx_s1;
         rx_s3 <= rx_s2;
         if (rx_s2 == rx_s3) begin
            rx_level <= rx_s3;
         end
      end
   end

   // =======================================================================
   // Bit timers, restarted at frame start
   logic tx_tick;
   logic rx_tick;
   wire  rx_begin;

   ucd_baud_timer #(.WIDTH(8)) u_tx_timer (
      .clk     (CLK_SYS),
      .rst     (RST),
      .restart (wr_data),
      .reload  (BAUD_RELOAD),
      .tick    (tx_tick)
   );

   ucd_baud_timer #(.WIDTH(8)) u_rx_timer (
      .clk     (CLK_SYS),
      .rst     (RST),
      .restart (rx_begin),
      .reload  (BAUD_RELOAD),
      .tick    (rx_tick)
   );

   // =======================================================================
   // Transmitter
   ucd_state_t tx_state;
   logic [7:0] tx_shift;
   logic [3:0] tx_bits;
   logic [1:0] tx_half;

   wire tx_bit_end  = tx_tick && (tx_half == `UCD_TICKS_PER_BIT - 2'h1);
   wire tx_last     = (tx_bits == `UCD_DATA_BITS - 4'h1);
   wire tx_to_stop  = tx_bit_end && ((tx_state == UCD_NINTH) ||
                      (tx_state == UCD_DATA && tx_last && !framing_mode_select));
   wire tx_to_ninth = tx_bit_end && (tx_state == UCD_DATA) && tx_last &&
                      framing_mode_select;
   wire tx_done_set = tx_to_stop;

   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         tx_state <= UCD_IDLE;
         tx_shift <= `UCD_RST_DATA;
         tx_bits  <= 4'h0;
         tx_half  <= 2'h0;
         TXD      <= 1'b1;
      end else if (wr_data) begin
         tx_state <= UCD_START;
         tx_shift <= SFR_WDATA;
         tx_bits  <= 4'h0;
         tx_half  <= 2'h0;
         TXD      <= 1'b0;
      end else begin
         if (tx_tick) begin
            tx_half <= tx_bit_end ? 2'h0 : tx_half + 2'h1;
         end
         if (tx_bit_end) begin
            case (tx_state)
               UCD_START: begin
                  tx_state <= UCD_DATA;
                  TXD      <= tx_shift[0];
               end
               UCD_DATA: begin
                  if (tx_to_ninth) begin
                     tx_state <= UCD_NINTH;
                     TXD      <= ninth_transmit_bit;
                  end else if (tx_to_stop) begin
                     tx_state <= UCD_STOP;
                     TXD      <= 1'b1;
                  end else begin
                     tx_bits  <= tx_bits + 4'h1;
                     tx_shift <= {1'b0, tx_shift[7:1]};
                     TXD      <= tx_shift[1];
                  end
               end
               UCD_NINTH: begin
                  tx_state <= UCD_STOP;
                  TXD      <= 1'b1;
               end
               UCD_STOP: begin
                  tx_state <= UCD_IDLE;
               end
               default: begin
                  tx_state <= UCD_IDLE;
                  TXD      <= 1'b1;
               end
            endcase
         end
      end
   end

   // =======================================================================
   // Receiver: first tick lands mid start bit, then two ticks per bit
   ucd_state_t rx_state;
   logic [7:0] rx_shift;
   logic [3:0] rx_bits;
   logic [1:0] rx_half;
   logic       rx_ninth;

   assign rx_begin = (rx_state == UCD_IDLE) && receive_enable_bit && !rx_level;
   wire rx_sample  = rx_tick && (rx_half == 2'h0);
   wire rx_last    = (rx_bits == `UCD_DATA_BITS - 4'h1);
   wire rx_stop_at = rx_sample && (rx_state == UCD_STOP);
   wire rx_bit9    = framing_mode_select ? rx_ninth : rx_level;
   wire rx_accept  = rx_stop_at && !receive_done_flag &&
                     (!multiprocessor_enable || rx_bit9);
   wire rx_done_set = rx_accept;

   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         rx_state <= UCD_IDLE;
         rx_shift <= 8'h00;
         rx_bits  <= 4'h0;
         rx_half  <= 2'h0;
         rx_ninth <= 1'b0;
      end else if (rx_begin) begin
         rx_state <= UCD_START;
         rx_bits  <= 4'h0;
         rx_half  <= 2'h0;
      end else begin
         if (rx_tick) begin
            rx_half <= (rx_half == `UCD_TICKS_PER_BIT - 2'h1) ? 2'h0 : rx_half + 2'h1;
         end
         if (rx_sample) begin
            case (rx_state)
               UCD_START: begin
                  rx_state <= rx_level ? UCD_IDLE : UCD_DATA;
               end
               UCD_DATA: begin
                  rx_shift <= {rx_level, rx_shift[7:1]};
                  rx_bits  <= rx_bits + 4'h1;
                  if (rx_last) begin
                     rx_state <= framing_mode_select ? UCD_NINTH : UCD_STOP;
                  end
               end
               UCD_NINTH: begin
                  rx_ninth <= rx_level;
                  rx_state <= UCD_STOP;
               end
               UCD_STOP: begin
                  rx_state <= UCD_IDLE;
               end
               default: begin
                  rx_state <= UCD_IDLE;
               end
            endcase
         end
      end
   end

   // =======================================================================
   // Control register, receive latch and read data
   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         framing_mode_select   <= 1'b0;
         multiprocessor_enable <= 1'b0;
         receive_enable_bit    <= 1'b0;
         ninth_transmit_bit    <= 1'b0;
         ninth_receive_bit     <= 1'b0;
         transmit_done_flag    <= 1'b0;
         receive_done_flag     <= 1'b0;
         receive_latch         <= `UCD_RST_DATA;
         SFR_RDATA             <= 8'h00;
      end else begin
         SFR_RDATA <= next_rdata;
         if (wr_ctrl) begin
            framing_mode_select   <= SFR_WDATA[`UCD_BIT_MODE];
            multiprocessor_enable <= SFR_WDATA[`UCD_BIT_MPE];
            receive_enable_bit    <= SFR_WDATA[`UCD_BIT_REN];
            ninth_transmit_bit    <= SFR_WDATA[`UCD_BIT_TB9];
         end
         if (rx_accept) begin
            receive_latch     <= rx_shift;
            ninth_receive_bit <= rx_bit9;
         end else if (wr_ctrl) begin
            ninth_receive_bit <= SFR_WDATA[`UCD_BIT_RB9];
         end
         // Hardware only sets; a set in the same cycle beats the write
         transmit_done_flag <= tx_done_set ||
                               (wr_ctrl ? SFR_WDATA[`UCD_BIT_TDONE] : transmit_done_flag);
         receive_done_flag  <= rx_done_set ||
                               (wr_ctrl ? SFR_WDATA[`UCD_BIT_RDONE] : receive_done_flag);
      end
   end

   assign IRQ = IRQ_ENABLE && (transmit_done_flag || receive_done_flag);

endmodule : ucd_serial_port

// ==== test/ucd_serial_port_assertions.sv ====
// Port-level assertions for the serial port control and data buffer.
// Assumes one clock and a synchronous active-high reset; bound below.
`timescale 1ns/1ns
module ucd_serial_port_checker (
   input wire logic       CLK_SYS,
   input wire logic       RST,
   input wire logic [7:0] SFR_ADDR,
   input wire logic       SFR_WR,
   input wire logic       SFR_RD,
   input wire logic [7:0] SFR_WDATA,
   input wire logic [7:0] SFR_RDATA,
   input wire logic       IRQ_ENABLE,
   input wire logic       TXD,
   input wire logic       IRQ
);
   // ========================================
   // Properties
   default clocking cb @(posedge CLK_SYS);
   endclocking
   default disable iff (RST);
   wire ctl_wr      = SFR_WR && SFR_ADDR == 8'h98;
   wire ctl_rd      = SFR_RD && SFR_ADDR == 8'h98;
   wire unmapped_rd = SFR_RD && SFR_ADDR[7:1] != 7'h4c;
   sequence ctl_write_then_read;
      ctl_wr ##1 !ctl_wr ##1 ctl_rd;
   endsequence
   sequence start_bit_held;
      !TXD [*2];
   endsequence
   property ctl_bit_kept(int b);
      ctl_write_then_read |=> SFR_RDATA[b] == $past(SFR_WDATA[b], 3);
   endproperty
   AST_IRQ_MASKED: assert property (!IRQ_ENABLE |-> !IRQ)
      else $error("irq high while disabled");
   AST_FLAG_KEPT: assert property (IRQ && !ctl_wr ##1 IRQ_ENABLE |-> IRQ)
      else $error("irq dropped without a control write");
   AST_TX_START: assert property (SFR_WR && SFR_ADDR == 8'h99 |=> start_bit_held)
      else $error("no start bit after data write");
   AST_RD_IDLE: assert property (!SFR_RD |=> SFR_RDATA == 8'h00)
      else $error("read data not zero without a read");
   AST_RD_UNMAPPED: assert property (unmapped_rd |=> SFR_RDATA == 8'h00)
      else $error("unmapped read not zero");
   AST_MODE_RB: assert property (ctl_bit_kept(7))
      else $error("mode bit lost");
   AST_REN_RB: assert property (ctl_bit_kept(4))
      else $error("receive enable bit lost");
   AST_TB9_RB: assert property (ctl_bit_kept(3))
      else $error("ninth transmit bit lost");
   AST_IRQ_ON_SET: assert property (ctl_wr && SFR_WDATA[1:0] != 2'b00 ##1 IRQ_ENABLE |-> IRQ)
      else $error("irq low after a done flag was set");
endmodule : ucd_serial_port_checker

bind ucd_serial_port ucd_serial_port_checker ucd_serial_port_checker_i (
   .CLK_SYS(CLK_SYS), .RST(RST), .SFR_ADDR(SFR_ADDR), .SFR_WR(SFR_WR), .SFR_RD(SFR_RD),
   .SFR_WDATA(SFR_WDATA), .SFR_RDATA(SFR_RDATA), .IRQ_ENABLE(IRQ_ENABLE), .TXD(TXD),
   .IRQ(IRQ));

// ==== test/ucd_remote_model.sv ====
// Remote serial device: sends frames to the port and captures its output.
// Assumes bit time given in system clock cycles and idle-high lines.
`timescale 1ns/1ns
module ucd_remote_model (
   input  wire logic clk,
   output logic      to_dut,
   input  wire logic from_dut
);
   initial to_dut = 1'b1;
   // ========================================
   // Frame out, LSB first, then idle gap
   task automatic send(input logic [8:0] d, input int nb, input logic stp, input int t);
      for (int k = 0; k < nb + 2; k++) begin
         @(posedge clk);
         to_dut <= (k == 0) ? 1'b0 : (k > nb) ? stp : d[k-1];
         repeat (t - 1) @(posedge clk);
      end
      @(posedge clk);
      to_dut <= 1'b1;
      repeat (2 * t) @(posedge clk);
   endtask : send
   // Frame in: nine positions sampled mid-bit
   task automatic get(input int t, output logic [8:0] q, output logic ok);
      ok = 1'b0;
      for (int n = 0; n < 50 && !ok; n++) begin
         @(posedge clk);
         ok = (from_dut === 1'b0);
      end
      repeat (t / 2) @(posedge clk);
      for (int k = 0; k < 9; k++) begin
         repeat (t) @(posedge clk);
         q[k] = from_dut;
      end
      repeat (t) @(posedge clk);
   endtask : get
endmodule : ucd_remote_model

// ==== test/tb_ucd_serial_port.sv ====
// Bench for the serial port: register tasks against a remote serial model.
// Assumes design, checker and remote model are compiled before it.
`timescale 1ns/1ns
module tb_ucd_serial_port;
   typedef struct packed {
      logic [7:0] ctl;
      logic [8:0] d;
      logic       stp;
      logic [7:0] ec;
      logic [7:0] ed;
   } ucd_rx_case_t;
   localparam logic [7:0] RELOAD = 8'hfc;
   localparam int         T      = 2 * (256 - RELOAD);
   logic         CLK_SYS, RST, SFR_WR, SFR_RD, IRQ_ENABLE, RXD, TXD, IRQ, ok;
   logic [7:0]   SFR_ADDR, SFR_WDATA, SFR_RDATA, BAUD_RELOAD;
   logic [8:0]   q;
   int           error_cnt   = 0;
   int           comparisons = 0;
   logic [7:0]   tx_ctl [4]  = '{8'h00, 8'h08, 8'h80, 8'h88};
   ucd_rx_case_t rx [7]      = '{'{8'h00, 9'h05a, 1'b1, 8'h40, 8'h00},
                                 '{8'h10, 9'h05a, 1'b1, 8'h55, 8'h5a},
                                 '{8'h30, 9'h099, 1'b0, 8'h70, 8'h5a},
                                 '{8'h10, 9'h044, 1'b0, 8'h51, 8'h44},
                                 '{8'hb0, 9'h0c3, 1'b1, 8'hf0, 8'h44},
                                 '{8'hb0, 9'h121, 1'b1, 8'hf5, 8'h21},
                                 '{8'h91, 9'h1ee, 1'b1, 8'hd1, 8'h21}};
   ucd_serial_port ucd_serial_port_i (
      .CLK_SYS(CLK_SYS), .RST(RST), .SFR_ADDR(SFR_ADDR), .SFR_WR(SFR_WR), .SFR_RD(SFR_RD),
      .SFR_WDATA(SFR_WDATA), .SFR_RDATA(SFR_RDATA), .BAUD_RELOAD(BAUD_RELOAD),
      .IRQ_ENABLE(IRQ_ENABLE), .RXD(RXD), .TXD(TXD), .IRQ(IRQ));
   ucd_remote_model ucd_remote_model_i (.clk(CLK_SYS), .to_dut(RXD), .from_dut(TXD));
   initial begin
      CLK_SYS = 1'b0;
      forever #10 CLK_SYS = ~CLK_SYS;
   end
   // ========================================
   // Access and compare tasks
   task automatic check(input string nm, input logic [8:0] exp, input logic [8:0] got);
      comparisons++;
      if (got !== exp) begin
         error_cnt++;
         $display("Error %s expected %h seen %h", nm, exp, got);
      end
   endtask : check
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge CLK_SYS);
      SFR_WR <= 1'b1;
      SFR_ADDR <= a;
      SFR_WDATA <= d;
      @(posedge CLK_SYS);
      SFR_WR <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string nm);
      @(posedge CLK_SYS);
      SFR_RD <= 1'b1;
      SFR_ADDR <= a;
      @(posedge CLK_SYS);
      SFR_RD <= 1'b0;
      #1 check(nm, {1'b0, exp}, {1'b0, SFR_RDATA});
   endtask : rd
   task automatic complete_run;
      $display("Comparisons %0d mismatches %0d", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : complete_run
   task automatic take_frame(input logic [8:0] exp);
      ucd_remote_model_i.get(T, q, ok);
      if (!ok) begin
         error_cnt++;
         $display("Error tx start expected 0 seen 1");
         complete_run();
      end else begin
         check("tx frame", exp, q);
      end
   endtask : take_frame
   // ========================================
   // Main sequence
   initial begin
      RST = 1'b1;
      SFR_WR = 1'b0;
      SFR_RD = 1'b0;
      SFR_ADDR = 8'h00;
      SFR_WDATA = 8'h00;
      IRQ_ENABLE = 1'b0;
      BAUD_RELOAD = RELOAD;
      repeat (2) @(posedge CLK_SYS);
      RST <= 1'b0;
      rd(8'h98, 8'h40, "control reset");
      rd(8'h99, 8'h00, "data reset");
      rd(8'h9a, 8'h00, "unmapped");
      wr(8'h98, 8'hb8);
      rd(8'h98, 8'hf8, "control rw");
      $display("Test registers done");
      for (int i = 0; i < 4; i++) begin
         @(posedge CLK_SYS);
         IRQ_ENABLE <= i[0];
         wr(8'h98, tx_ctl[i]);
         wr(8'h99, 8'ha5 ^ i[7:0]);
         take_frame({tx_ctl[i][7] ? tx_ctl[i][3] : 1'b1, 8'ha5 ^ i[7:0]});
         rd(8'h98, tx_ctl[i] | 8'h42, "tx done");
         check("irq", {8'h00, i[0]}, {8'h00, IRQ});
      end
      $display("Test transmit done");
      for (int i = 0; i < 7; i++) begin
         wr(8'h98, rx[i].ctl);
         ucd_remote_model_i.send(rx[i].d, rx[i].ctl[7] ? 9 : 8, rx[i].stp, T);
         rd(8'h98, rx[i].ec, "rx status");
         rd(8'h99, rx[i].ed, "rx latch");
      end
      $display("Test receive done");
      wr(8'h99, 8'h77);
      rd(8'h99, 8'h21, "latch in tx");
      take_frame(9'h077);
      wr(8'h98, 8'h00);
      #1 check("irq clear", 9'h000, {8'h00, IRQ});
      $display("Test overlap done");
      // Reset in mid-frame with both flags set by software
      wr(8'h98, 8'h13);
      wr(8'h99, 8'h0f);
      repeat (4) @(posedge CLK_SYS);
      RST <= 1'b1;
      repeat (2) @(posedge CLK_SYS);
      RST <= 1'b0;
      #1 check("reset txd", 9'h001, {8'h00, TXD});
      check("reset irq", 9'h000, {8'h00, IRQ});
      rd(8'h98, 8'h40, "control after reset");
      rd(8'h99, 8'h00, "data after reset");
      wr(8'h9a, 8'hff);
      rd(8'h98, 8'h40, "unmapped write");
      $display("Test reset done");
      complete_run();
   end
endmodule : tb_ucd_serial_port
